/* File: logic/acs_cfg.svh */
// Register offsets, field positions, reset values and the behaviour list
// Behaviour
// - Channel-zero config is a 16-bit register at 0x10, reset value 0x8001.
// - Bit 15 enables channel zero; it resets to one.
// - With several channels enabled, conversions step through them without host help.
// - Bits 14:12 pick setup n of eight; reset zero.
// - A setup is four registers; the picked group governs the channel. Here each setup is a single 32-bit word.
// - Bits 9:5 route the positive input; reset selects input zero.
// - Bits 4:0 route the negative input; reset selects input one.
`ifndef ACS_CFG_SVH
`define ACS_CFG_SVH
// ==========================================================
// Register map (byte addresses)
`define ACS_CH0_OFFSET 12'h010
`define ACS_CH_STRIDE 12'h004
`define ACS_OTHER_EN_OFFSET 12'h080
`define ACS_SEQ_CTRL_OFFSET 12'h084
`define ACS_SEQ_STAT_OFFSET 12'h088
`define ACS_SETUP_BASE 12'h100
// ==========================================================
// Field positions and reset values
`define ACS_EN_BIT 15
`define ACS_SETUP_MSB 14
`define ACS_SETUP_LSB 12
`define ACS_RSV_MSB 11
`define ACS_RSV_LSB 10
`define ACS_POS_MSB 9
`define ACS_POS_LSB 5
`define ACS_NEG_MSB 4
`define ACS_NEG_LSB 0
`define ACS_CH0_RESET 16'h8001
`define ACS_CH0_WMASK 16'hf3ff
`define ACS_SETUP_RESET 32'h00000000
// ==========================================================
// Timing: dwell per channel in ns and derived cycles at 100 MHz
`define ACS_CLK_NS 10
`define ACS_DWELL_NS 200
`define ACS_DWELL_CYC ((`ACS_DWELL_NS + `ACS_CLK_NS - 1) / `ACS_CLK_NS)
`endif

/* File: logic/acs_pkg.sv */
// Types shared by the channel-zero select block
package acs_pkg;
   typedef enum logic [1:0] {ACS_IDLE, ACS_CONVERT, ACS_ADVANCE} acs_seq_t;
   typedef logic [15:0] acs_chreg_t;
endpackage : acs_pkg

/* File: logic/acs_next_channel.sv */
// Finds the next enabled channel above the current one, wrapping around
`timescale 1ns/1ns
`default_nettype none
module acs_next_channel #(
   parameter int NCH = 16,
   parameter int CW = 4
) (
   input wire logic [NCH-1:0] enables,
   input wire logic [CW-1:0] current,
   output logic [CW-1:0] nextCh,
   output logic anyEnabled
);
   // ==========================================================
   // Ascending search with wrap
   always_comb begin
      logic found;
      logic [CW-1:0] idx;
      found = 1'b0;
      nextCh = current;
      idx = current;
      for (int k = 1; k <= NCH; k++) begin
         idx = CW'((int'(current) + k) % NCH);
         if (!found && enables[idx]) begin
            nextCh = idx;
            found = 1'b1;
         end
      end
      anyEnabled = |enables;
   end
endmodule : acs_next_channel
`default_nettype wire

/* File: logic/acs_channel_select.sv */
// Channel-zero configuration register with APB access and channel sequencer
`timescale 1ns/1ns
`default_nettype none
`include "acs_cfg.svh"
module acs_channel_select import acs_pkg::*; #(
   parameter int NCH = 16,
   parameter int NSETUP = 8
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic convActive,
   output logic [3:0] activeChannel,
   output logic [2:0] activeSetup,
   output logic [4:0] positiveInput,
   output logic [4:0] negativeInput,
   output logic [31:0] activeSetupWord,
   output logic convStart
);
   // ==========================================================
   // Register state
   acs_chreg_t chanZero_q, chanZero_d;
   logic [NCH-1:1] otherEn_q, otherEn_d;
   logic run_q, run_d;
   logic [31:0] setupMem_q [NSETUP];
   logic [31:0] setupMem_d [NSETUP];
   logic [31:0] prdata_q, prdata_d;
   logic pready_q, pready_d;
   logic pslverr_q, pslverr_d;

   // Address decode, used for both read and write paths
   function automatic logic isSetup(input logic [11:0] a);
      return (a >= `ACS_SETUP_BASE) && (a < `ACS_SETUP_BASE + 12'(4 * NSETUP))
         && (a[1:0] == 2'b00);
   endfunction : isSetup

   function automatic logic isMapped(input logic [11:0] a);
      return (a == `ACS_CH0_OFFSET) || (a == `ACS_OTHER_EN_OFFSET)
         || (a == `ACS_SEQ_CTRL_OFFSET) || (a == `ACS_SEQ_STAT_OFFSET) || isSetup(a);
   endfunction : isMapped

   logic [2:0] setupIdx;
   assign setupIdx = paddr[4:2];

   // ==========================================================
   // Sequencer state
   acs_seq_t seq_q, seq_d;
   logic [3:0] chan_q, chan_d;
   logic [7:0] dwell_q, dwell_d;
   logic conv_q, conv_d;
   logic start_q, start_d;
   logic [2:0] setup_q, setup_d;
   logic [4:0] pos_q, pos_d;
   logic [4:0] neg_q, neg_d;
   logic [31:0] sword_q, sword_d;
   logic [NCH-1:0] enables;
   logic [3:0] nextCh;
   logic [3:0] searchFrom;
   logic anyEn;

   assign enables = {otherEn_q, chanZero_q[`ACS_EN_BIT]};

   // From idle, search above the top channel so the wrap lands on the lowest enabled one
   assign searchFrom = (seq_q == ACS_IDLE) ? 4'(NCH - 1) : chan_q;

   acs_next_channel #(
      .NCH(NCH),
      .CW(4)
   ) u_next (
      .enables(enables),
      .current(searchFrom),
      .nextCh(nextCh),
      .anyEnabled(anyEn)
   );

   // ==========================================================
   // APB slave: one wait state per access phase, reads registered at access
   always_comb begin
      logic access;
      access = psel && penable && !pready_q;
      chanZero_d = chanZero_q;
      otherEn_d = otherEn_q;
      run_d = run_q;
      setupMem_d = setupMem_q;
      prdata_d = prdata_q;
      pready_d = 1'b0;
      pslverr_d = 1'b0;
      // Writes land only at the edge where the master sees pready high
      if (psel && penable && pready_q && pwrite) begin
         if (paddr == `ACS_CH0_OFFSET) begin
            // sixteen-bit register; reserved bits kept zero
            chanZero_d = pwdata[15:0] & `ACS_CH0_WMASK;
         end
         if (paddr == `ACS_OTHER_EN_OFFSET) begin
            otherEn_d = pwdata[NCH-1:1];
         end
         if (paddr == `ACS_SEQ_CTRL_OFFSET) begin
            run_d = pwdata[0];
         end
         if (isSetup(paddr)) begin
            // setup groups live in this array
            setupMem_d[setupIdx] = pwdata;
         end
      end
      if (access) begin
         pready_d = 1'b1;
         pslverr_d = !isMapped(paddr);
         if (!pwrite) begin
            prdata_d = 32'h00000000;
            if (paddr == `ACS_CH0_OFFSET) begin
               prdata_d = {16'h0000, chanZero_q};
            end
            if (paddr == `ACS_OTHER_EN_OFFSET) begin
               prdata_d = {16'h0000, otherEn_q, 1'b0};
            end
            if (paddr == `ACS_SEQ_CTRL_OFFSET) begin
               prdata_d = {31'h00000000, run_q};
            end
            if (paddr == `ACS_SEQ_STAT_OFFSET) begin
               prdata_d = {26'h0000000, seq_q == ACS_CONVERT, conv_q, chan_q};
            end
            if (isSetup(paddr)) begin
               prdata_d = setupMem_q[setupIdx];
            end
         end
      end
   end

   // Registers of the bus slave
   always_ff @(posedge clk) begin
      if (srst) begin
         chanZero_q <= `ACS_CH0_RESET;
         otherEn_q <= '0;
         run_q <= 1'b0;
         for (int i = 0; i < NSETUP; i++) begin
            setupMem_q[i] <= `ACS_SETUP_RESET;
         end
         prdata_q <= 32'h00000000;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
      end else begin
         chanZero_q <= chanZero_d;
         otherEn_q <= otherEn_d;
         run_q <= run_d;
         setupMem_q <= setupMem_d;
         prdata_q <= prdata_d;
         pready_q <= pready_d;
         pslverr_q <= pslverr_d;
      end
   end

   // ==========================================================
   // Sequencer: dwell on each enabled channel, then step to the next
   always_comb begin
      seq_d = seq_q;
      chan_d = chan_q;
      dwell_d = dwell_q;
      conv_d = conv_q;
      start_d = 1'b0;
      setup_d = setup_q;
      pos_d = pos_q;
      neg_d = neg_q;
      sword_d = sword_q;
      case (seq_q)
         ACS_IDLE: begin
            conv_d = 1'b0;
            if (run_q && anyEn) begin
               // Start on the lowest enabled channel
               chan_d = nextCh;
               seq_d = ACS_ADVANCE;
            end
         end
         ACS_ADVANCE: begin
            // Route channel settings; only channel zero is held here
            if (chan_q == 4'h0) begin
               setup_d = chanZero_q[`ACS_SETUP_MSB:`ACS_SETUP_LSB];
               pos_d = chanZero_q[`ACS_POS_MSB:`ACS_POS_LSB];
               neg_d = chanZero_q[`ACS_NEG_MSB:`ACS_NEG_LSB];
            end else begin
               setup_d = 3'h0;
               pos_d = 5'h00;
               neg_d = 5'h01;
            end
            sword_d = setupMem_q[setup_d];
            dwell_d = 8'(`ACS_DWELL_CYC);
            conv_d = 1'b1;
            start_d = 1'b1;
            seq_d = ACS_CONVERT;
         end
         ACS_CONVERT: begin
            if (dwell_d > 8'h01) begin
               dwell_d = dwell_q - 8'h01;
            end
            if (dwell_q <= 8'h01) begin
               conv_d = 1'b0;
               if (!run_q || !anyEn) begin
                  seq_d = ACS_IDLE;
               end else begin
                  chan_d = nextCh;
                  seq_d = ACS_ADVANCE;
               end
            end
         end
         default: begin
            seq_d = ACS_IDLE;
         end
      endcase
   end

   // Sequencer registers
   always_ff @(posedge clk) begin
      if (srst) begin
         seq_q <= ACS_IDLE;
         chan_q <= 4'h0;
         dwell_q <= 8'h00;
         conv_q <= 1'b0;
         start_q <= 1'b0;
         setup_q <= 3'h0;
         pos_q <= 5'h00;
         neg_q <= 5'h01;
         sword_q <= 32'h00000000;
      end else begin
         seq_q <= seq_d;
         chan_q <= chan_d;
         dwell_q <= dwell_d;
         conv_q <= conv_d;
         start_q <= start_d;
         setup_q <= setup_d;
         pos_q <= pos_d;
         neg_q <= neg_d;
         sword_q <= sword_d;
      end
   end

   // Outputs straight from flip-flops
   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign convActive = conv_q;
   assign activeChannel = chan_q;
   assign activeSetup = setup_q;
   assign positiveInput = pos_q;
   assign negativeInput = neg_q;
   assign activeSetupWord = sword_q;
   assign convStart = start_q;
endmodule : acs_channel_select
`default_nettype wire

/* File: testbench/acs_channel_select_asserts.sv */
// Checker for the channel-zero select block
`timescale 1ns/1ns
`default_nettype none
`include "acs_cfg.svh"
module acs_channel_select_asserts (
   input wire logic clk,
   input wire logic srst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic convActive,
   input wire logic [3:0] activeChannel,
   input wire logic [2:0] activeSetup,
   input wire logic [4:0] positiveInput,
   input wire logic [4:0] negativeInput,
   input wire logic convStart
);
   logic [15:0] shQ;
   logic [15:0] shD;
   // ==========================================
   // Shadow register, masked so reserved bits stay zero
   always_comb begin
      shD = shQ;
      if (psel && penable && pready && pwrite && paddr == 12'h010) begin
         shD = pwdata[15:0] & `ACS_CH0_WMASK;
      end
   end
   // Reset value tracked as well
   always_ff @(posedge clk) begin
      shQ <= srst ? `ACS_CH0_RESET : shD;
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);
   // ==========================================
   // Bus and sequencer properties
   property p_rdy; psel && penable && !pready |=> pready ##1 !pready; endproperty
   a_rdy: assert property (p_rdy) else $error("pready not a single pulse");
   property p_read; pready && !pwrite && paddr == 12'h010 |-> prdata == {16'h0000, shQ}; endproperty
   a_read: assert property (p_read) else $error("channel-zero readback wrong");
   property p_rsv; pready && !pwrite && paddr == 12'h010 |-> prdata[11:10] == 2'b00; endproperty
   a_rsv: assert property (p_rsv) else $error("reserved bits not zero");
   property p_unmap; pready && !pwrite && paddr == 12'h200 |-> pslverr && prdata == 32'h0; endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read not refused");
   property p_start; $rose(convActive) |-> convStart; endproperty
   a_start: assert property (p_start) else $error("dwell without start pulse");
   property p_dwell; $rose(convActive) |-> convActive[*8] ##1 convActive[*8] ##1 convActive[*4]
      ##1 !convActive; endproperty
   a_dwell: assert property (p_dwell) else $error("dwell length wrong");
   property p_pulse; convStart |=> !convStart; endproperty
   a_pulse: assert property (p_pulse) else $error("start pulse too long");
   property p_route; convStart && activeChannel == 4'h0 |-> activeSetup == shQ[14:12]
      && positiveInput == shQ[9:5] && negativeInput == shQ[4:0]; endproperty
   a_route: assert property (p_route) else $error("channel-zero routing wrong");
   property p_skip; convStart |-> activeChannel != 4'h0 || shQ[15]; endproperty
   a_skip: assert property (p_skip) else $error("disabled channel zero converted");
endmodule : acs_channel_select_asserts
`default_nettype wire

/* File: testbench/tb.sv */
// Testbench for the channel-zero select block
`timescale 1ns/1ns
`default_nettype none
module tb;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rd, activeSetupWord;
   logic pready, pslverr, convActive, convStart, err;
   logic [3:0] activeChannel, ch;
   logic [2:0] activeSetup;
   logic [4:0] positiveInput, negativeInput;
   int failCount = 0;
   int nCompared = 0;
   int cycles = 0;
   int order [4] = '{3, 15, 0, 3};
   always #5 clk = ~clk;
   acs_channel_select acs_channel_select_inst (.clk(clk), .srst(srst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .convActive(convActive),
      .activeChannel(activeChannel), .activeSetup(activeSetup), .positiveInput(positiveInput),
      .negativeInput(negativeInput), .activeSetupWord(activeSetupWord), .convStart(convStart));
   // ==========================================
   // Hang guard: far above the few hundred cycles needed
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         failCount++;
         printVerdict();
      end
   end
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      nCompared++;
      if (got !== exp) begin
         failCount++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   // One APB transfer; request held until pready is seen high
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd = prdata;
      err = pslverr;
      if (n >= 50) chk("pready", 32'h1, 32'h0);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : xfer
   // Bounded wait for the next conversion start
   task automatic waitStart;
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (convStart !== 1'b1 && n < 100);
      ch = activeChannel;
      if (n >= 100) chk("convStart", 32'h1, 32'h0);
   endtask : waitStart
   task printVerdict;
      $display("compared %0d mismatches %0d", nCompared, failCount);
      if (failCount == 0 && nCompared > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : printVerdict
   // ==========================================
   // Main sequence
   initial begin
      repeat (5) @(posedge clk);
      srst <= 1'b0;
      xfer(1'b0, 12'h010, 32'h0);
      chk("ch0 reset", 32'h8001, rd);
      chk("mapped ok", 32'h0, {31'h0, err});
      xfer(1'b1, 12'h010, 32'hffffffff);
      xfer(1'b0, 12'h010, 32'h0);
      chk("ch0 reserved", 32'hf3ff, rd);
      xfer(1'b0, 12'h200, 32'h0);
      chk("unmapped", 32'h1, {31'h0, err});
      for (int n = 0; n < 8; n++) xfer(1'b1, 12'h100 + 12'(4 * n), 32'ha5000000 | n);
      xfer(1'b1, 12'h084, 32'h1);
      // Each setup and input codes 0 to 7 on channel zero, written just after a start
      for (int n = 0; n < 8; n++) begin
         waitStart();
         xfer(1'b1, 12'h010, 32'h8000 | (n << 12) | (n << 5) | (7 - n));
         waitStart();
         chk("setup", 32'(n), {29'h0, activeSetup});
         chk("setup word", 32'ha5000000 | n, activeSetupWord);
         chk("positive", 32'(n), {27'h0, positiveInput});
         chk("negative", 32'(7 - n), {27'h0, negativeInput});
      end
      // Ascending order with wrap over channels 0, 3 and 15, all sharing setup zero
      xfer(1'b1, 12'h010, 32'h8001);
      xfer(1'b1, 12'h080, 32'h8008);
      foreach (order[i]) begin
         waitStart();
         chk("order", 32'(order[i]), {28'h0, ch});
         chk("shared setup", 32'h0, {29'h0, activeSetup});
      end
      // Channel zero dropped from the sequence
      xfer(1'b1, 12'h010, 32'h0001);
      foreach (order[i]) begin
         waitStart();
         chk("skip", (i % 2) ? 32'h3 : 32'hf, {28'h0, ch});
      end
      printVerdict();
   end
endmodule : tb
bind acs_channel_select acs_channel_select_asserts acs_channel_select_asserts_inst (
   .clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .convActive(convActive), .activeChannel(activeChannel), .activeSetup(activeSetup),
   .positiveInput(positiveInput), .negativeInput(negativeInput), .convStart(convStart));
`default_nettype wire
